//--- src/rops_pin_router.sv
// Per-pin output multiplexer with registered pin level and drive enable
`timescale 1ns/100ps
`default_nettype none
module rops_pin_router (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	rops_route_if.router route,
	output logic [rops_pkg::NUM_PINS-1:0] pin_out,
	output logic [rops_pkg::NUM_PINS-1:0] pin_drive
);
	genvar gi;
	generate
		for (gi = 0; gi < rops_pkg::NUM_PINS; gi++)
		begin : g_pin
			logic next_drive;
			logic next_level;
			always_comb
			begin
				next_drive = 1'b1;
				next_level = 1'b0;
				unique case (rops_pkg::PIN_GROUP[gi])
					rops_pkg::GRP_ONE:
					begin
						unique case (route.sel[gi])
							rops_pkg::CODE_G1_UART1_TX: next_level = route.periph[rops_pkg::PER_UART1_TX];
							rops_pkg::CODE_G1_UART2_RTS: next_level = route.periph[rops_pkg::PER_UART2_RTS];
							rops_pkg::CODE_G1_SPI1_SS: next_level = route.periph[rops_pkg::PER_SPI1_SS];
							rops_pkg::CODE_G1_CMP2: next_level = route.periph[rops_pkg::PER_CMP2];
							default: next_drive = 1'b0;
						endcase
					end
					rops_pkg::GRP_TWO:
					begin
						unique case (route.sel[gi])
							rops_pkg::CODE_G23_SPI1_SDO: next_level = route.periph[rops_pkg::PER_SPI1_SDO];
							rops_pkg::CODE_G23_SPI2_SDO: next_level = route.periph[rops_pkg::PER_SPI2_SDO];
							rops_pkg::CODE_G2_OUTCMP2: next_level = route.periph[rops_pkg::PER_OUTCMP2];
							default: next_drive = 1'b0;
						endcase
					end
					rops_pkg::GRP_THREE:
					begin
						unique case (route.sel[gi])
							rops_pkg::CODE_G23_SPI1_SDO: next_level = route.periph[rops_pkg::PER_SPI1_SDO];
							rops_pkg::CODE_G23_SPI2_SDO: next_level = route.periph[rops_pkg::PER_SPI2_SDO];
							rops_pkg::CODE_G3_OUTCMP4: next_level = route.periph[rops_pkg::PER_OUTCMP4];
							default: next_drive = 1'b0;
						endcase
					end
					rops_pkg::GRP_FOUR:
					begin
						unique case (route.sel[gi])
							rops_pkg::CODE_G4_SPI2_SS: next_level = route.periph[rops_pkg::PER_SPI2_SS];
							rops_pkg::CODE_G4_OUTCMP3: next_level = route.periph[rops_pkg::PER_OUTCMP3];
							rops_pkg::CODE_G4_CMP1: next_level = route.periph[rops_pkg::PER_CMP1];
							default: next_drive = 1'b0;
						endcase
					end
				endcase
			end

			// Registered so that pins never glitch through the decode
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					pin_out[gi] <= 1'b0;
					pin_drive[gi] <= 1'b0;
				end
				else if (ce)
				begin
					pin_out[gi] <= next_level;
					pin_drive[gi] <= next_drive;
				end
			end
		end
	endgenerate
endmodule : rops_pin_router
`default_nettype wire

//--- src/rops_pin_select.sv
// Remappable output pin select: AXI4-Lite register file and pin routing
// Overview of operation
// - Group one: 0001 UART1 TX, 0010 UART2 RTS
// - Group one: 0011 SPI1 SS, 0111 CMP2
// - Group two: SPI1 data, SPI2 data, compare two
// - Group three: SPI1 data, SPI2 data, compare four
// - Group four: SPI2 select, compare three, comparator one
// - One word each, upper bits zero, reset zero
// - Two high port A pins only in large package
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module rops_pin_select #(
	parameter bit LARGE_PACKAGE = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [rops_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [rops_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [rops_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [rops_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic uart_one_transmit_out,
	input wire logic uart_two_request_to_send_out,
	input wire logic spi_one_slave_select_out,
	input wire logic spi_two_slave_select_out,
	input wire logic spi_one_serial_data_out,
	input wire logic spi_two_serial_data_out,
	input wire logic output_compare_two,
	input wire logic output_compare_three,
	input wire logic output_compare_four,
	input wire logic comparator_one_output,
	input wire logic comparator_two_output,
	output logic [rops_pkg::NUM_PINS-1:0] pin_out,
	output logic [rops_pkg::NUM_PINS-1:0] pin_drive
);
	localparam int IDX_W = $clog2(rops_pkg::NUM_PINS);

	rops_route_if route ();

	logic aw_held;
	logic [rops_pkg::ADDR_W-1:0] aw_addr;
	logic w_held;
	logic [rops_pkg::SEL_W-1:0] w_field;
	logic w_lane0;
	logic [rops_pkg::SEL_W-1:0] sel [rops_pkg::NUM_PINS];
	logic wr_hit;
	logic [IDX_W-1:0] wr_idx;
	logic rd_hit;
	logic [IDX_W-1:0] rd_idx;
	logic do_write;

	// Returns whether an offset names an implemented register
	function automatic logic reg_hit(input logic [rops_pkg::ADDR_W-1:0] addr);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < rops_pkg::NUM_PINS; i++)
		begin
			if (addr == rops_pkg::PIN_OFFSET[i] && (LARGE_PACKAGE || !rops_pkg::PIN_LARGE_ONLY[i]))
			begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction : reg_hit

	function automatic logic [IDX_W-1:0] reg_index(input logic [rops_pkg::ADDR_W-1:0] addr);
		logic [IDX_W-1:0] idx;
		idx = '0;
		for (int i = 0; i < rops_pkg::NUM_PINS; i++)
		begin
			if (addr == rops_pkg::PIN_OFFSET[i])
			begin
				idx = IDX_W'(i);
			end
		end
		return idx;
	endfunction : reg_index

	always_comb
	begin
		wr_hit = reg_hit(aw_addr);
		wr_idx = reg_index(aw_addr);
		rd_hit = reg_hit(s_axi_araddr);
		rd_idx = reg_index(s_axi_araddr);
	end

	assign do_write = aw_held && w_held && !s_axi_bvalid;

	// Write address channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			s_axi_awready <= 1'b1;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				aw_held <= 1'b0;
				s_axi_awready <= 1'b1;
			end
		end
	end

	// Write data channel; only byte lane 0 carries field bits
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held <= 1'b0;
			w_field <= '0;
			w_lane0 <= 1'b0;
			s_axi_wready <= 1'b1;
		end
		else if (ce)
		begin
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_field <= s_axi_wdata[rops_pkg::SEL_W-1:0];
				w_lane0 <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				w_held <= 1'b0;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Write response, one cycle after both halves are held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= rops_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? rops_pkg::RESP_OKAY : rops_pkg::RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Selection fields
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < rops_pkg::NUM_PINS; i++)
			begin
				sel[i] <= rops_pkg::REG_RESET[rops_pkg::SEL_W-1:0];
			end
		end
		else if (ce && do_write && wr_hit && w_lane0)
		begin
			sel[wr_idx] <= w_field;
		end
	end

	// Read channel; absent and unmapped offsets answer SLVERR with zero data
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= rops_pkg::REG_RESET;
			s_axi_rresp <= rops_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= rd_hit ? rops_pkg::RESP_OKAY : rops_pkg::RESP_SLVERR;
				s_axi_rdata <= rd_hit ? {{(rops_pkg::DATA_W-rops_pkg::SEL_W){1'b0}}, sel[rd_idx]}
					: rops_pkg::REG_RESET;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Absent registers keep their pins disconnected: their fields are never written
	always_comb
	begin
		for (int i = 0; i < rops_pkg::NUM_PINS; i++)
		begin
			route.sel[i] = sel[i];
		end
		route.periph = '0;
		route.periph[rops_pkg::PER_UART1_TX] = uart_one_transmit_out;
		route.periph[rops_pkg::PER_UART2_RTS] = uart_two_request_to_send_out;
		route.periph[rops_pkg::PER_SPI1_SS] = spi_one_slave_select_out;
		route.periph[rops_pkg::PER_SPI2_SS] = spi_two_slave_select_out;
		route.periph[rops_pkg::PER_SPI1_SDO] = spi_one_serial_data_out;
		route.periph[rops_pkg::PER_SPI2_SDO] = spi_two_serial_data_out;
		route.periph[rops_pkg::PER_OUTCMP2] = output_compare_two;
		route.periph[rops_pkg::PER_OUTCMP3] = output_compare_three;
		route.periph[rops_pkg::PER_OUTCMP4] = output_compare_four;
		route.periph[rops_pkg::PER_CMP1] = comparator_one_output;
		route.periph[rops_pkg::PER_CMP2] = comparator_two_output;
	end

	rops_pin_router u_router (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.route(route.router),
		.pin_out(pin_out),
		.pin_drive(pin_drive)
	);
endmodule : rops_pin_select
`default_nettype wire

//--- src/rops_pkg.sv
// Constants for the remappable output pin select block
package rops_pkg;
	localparam int NUM_PINS = 32;
	localparam int SEL_W = 4;
	localparam int NUM_PERIPH = 12;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;

	// Register byte offsets, one per pin, in pin index order
	localparam logic [ADDR_W-1:0] PIN_OFFSET [NUM_PINS] = '{
		16'hFB00, 16'hFB04, 16'hFB08, 16'hFB0C, 16'hFB10, 16'hFB20, 16'hFB24, 16'hFB2C,
		16'hFB30, 16'hFB34, 16'hFB38, 16'hFB3C, 16'hFB40, 16'hFB44, 16'hFB48, 16'hFB4C,
		16'hFB50, 16'hFB54, 16'hFB58, 16'hFB5C, 16'hFB60, 16'hFB64, 16'hFB68, 16'hFB6C,
		16'hFB70, 16'hFB74, 16'hFB78, 16'hFB7C, 16'hFB80, 16'hFB84, 16'hFB88, 16'hFB8C
	};

	// Code table group of each pin
	localparam logic [1:0] GRP_ONE = 2'h0;
	localparam logic [1:0] GRP_TWO = 2'h1;
	localparam logic [1:0] GRP_THREE = 2'h2;
	localparam logic [1:0] GRP_FOUR = 2'h3;
	localparam logic [1:0] PIN_GROUP [NUM_PINS] = '{
		2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h1, 2'h1, 2'h3,
		2'h1, 2'h2, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0,
		2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2,
		2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3
	};

	// Pins whose register exists only in the largest package
	localparam logic [NUM_PINS-1:0] PIN_LARGE_ONLY = 32'h0000_0060;

	// Selection codes
	localparam logic [SEL_W-1:0] CODE_NO_CONNECT = 4'h0;
	localparam logic [SEL_W-1:0] CODE_G1_UART1_TX = 4'h1;
	localparam logic [SEL_W-1:0] CODE_G1_UART2_RTS = 4'h2;
	localparam logic [SEL_W-1:0] CODE_G1_SPI1_SS = 4'h3;
	localparam logic [SEL_W-1:0] CODE_G1_CMP2 = 4'h7;
	localparam logic [SEL_W-1:0] CODE_G23_SPI1_SDO = 4'h3;
	localparam logic [SEL_W-1:0] CODE_G23_SPI2_SDO = 4'h4;
	localparam logic [SEL_W-1:0] CODE_G2_OUTCMP2 = 4'h5;
	localparam logic [SEL_W-1:0] CODE_G3_OUTCMP4 = 4'h5;
	localparam logic [SEL_W-1:0] CODE_G4_SPI2_SS = 4'h4;
	localparam logic [SEL_W-1:0] CODE_G4_OUTCMP3 = 4'h5;
	localparam logic [SEL_W-1:0] CODE_G4_CMP1 = 4'h7;

	// Bit positions of the peripheral outputs in the routing vector
	localparam int PER_UART1_TX = 0;
	localparam int PER_UART2_RTS = 1;
	localparam int PER_SPI1_SS = 2;
	localparam int PER_SPI2_SS = 3;
	localparam int PER_SPI1_SDO = 4;
	localparam int PER_SPI2_SDO = 5;
	localparam int PER_OUTCMP2 = 6;
	localparam int PER_OUTCMP3 = 7;
	localparam int PER_OUTCMP4 = 8;
	localparam int PER_CMP1 = 9;
	localparam int PER_CMP2 = 10;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
endpackage : rops_pkg

//--- src/rops_route_if.sv
// Selection fields and peripheral outputs passed from the register file to the router
`timescale 1ns/100ps
`default_nettype none
interface rops_route_if;
	logic [rops_pkg::SEL_W-1:0] sel [rops_pkg::NUM_PINS];
	logic [rops_pkg::NUM_PERIPH-1:0] periph;
	modport ctrl (output sel, output periph);
	modport router (input sel, input periph);
endinterface : rops_route_if
`default_nettype wire

//--- test/rops_monitor.sv
// Port checker for the pin select block, bound to its top module
`timescale 1ns/100ps
`default_nettype none
module rops_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_drive
);
	default clocking cb @(posedge aclk);
	endclocking
	// A low clock enable freezes the block, so nothing is judged then
	default disable iff (!aresetn || !ce);
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_done;
		s_axi_bvalid && s_axi_bready;
	endsequence
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	property p_rd_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
	property p_rd_upper;
		s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0;
	endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken early");
	property p_wr_answer;
		s_wr_both |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("response dropped");
	property p_b_done;
		s_b_done |=> !s_axi_bvalid ##[0:1] (s_axi_awready && s_axi_wready);
	endproperty
	a_b_done: assert property (p_b_done) else $error("write not closed");
	property p_undriven_low;
		(pin_out & ~pin_drive) == 32'h0;
	endproperty
	a_undriven_low: assert property (p_undriven_low) else $error("undriven pin high");
	property p_reset_quiet;
		$rose(aresetn) |-> pin_drive == 32'h0;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("pin driven at reset");
endmodule : rops_monitor
bind rops_pin_select rops_monitor i_rops_monitor (.aclk, .aresetn, .ce, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_out,
	.pin_drive);
`default_nettype wire

//--- test/rops_periph_model.sv
// Peripheral output levels feeding the pin select block
`timescale 1ns/100ps
`default_nettype none
module rops_periph_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [10:0] lvl,
	output logic [10:0] per
);
	// Levels change only just after an edge, as real peripheral flops do
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			per <= 11'h000;
		else
			per <= lvl;
	end
endmodule : rops_periph_model
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the pin select block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic [15:0] s_axi_awaddr = 16'h0000;
	logic [2:0] s_axi_awprot = 3'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [15:0] s_axi_araddr = 16'h0000;
	logic [2:0] s_axi_arprot = 3'h0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic [10:0] lvl = 11'h000;
	logic [10:0] per;
	logic [31:0] pin_out;
	logic [31:0] pin_drive;
	logic [31:0] rnd = 32'h0000_0001;
	logic [3:0] fld [32];
	logic [15:0] bad [3] = '{16'hFB14, 16'hFB02, 16'hFB90};
	int n_fail = 0;
	int n_compared = 0;

	rops_periph_model i_rops_periph_model (.aclk, .aresetn, .lvl, .per);
	rops_pin_select i_rops_pin_select (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.uart_one_transmit_out(per[0]), .uart_two_request_to_send_out(per[1]),
		.spi_one_slave_select_out(per[2]), .spi_two_slave_select_out(per[3]),
		.spi_one_serial_data_out(per[4]), .spi_two_serial_data_out(per[5]),
		.output_compare_two(per[6]), .output_compare_three(per[7]), .output_compare_four(per[8]),
		.comparator_one_output(per[9]), .comparator_two_output(per[10]), .pin_out, .pin_drive);

	initial
		forever #50 aclk = ~aclk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Index of the peripheral level a group and code route, or -1 when undriven
	function automatic int src(input logic [1:0] g, input logic [3:0] c);
		case ({g, c})
			6'h01: return 0;
			6'h02: return 1;
			6'h03: return 2;
			6'h07: return 10;
			6'h13, 6'h23: return 4;
			6'h14, 6'h24: return 5;
			6'h15: return 6;
			6'h25: return 8;
			6'h34: return 3;
			6'h35: return 7;
			6'h37: return 9;
			default: return -1;
		endcase
	endfunction : src

	task automatic end_of_test;
		$display("Compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic limit(input int n);
		if (n == 50)
		begin
			n_fail++;
			$display("MISMATCH at %0t: no bus answer", $time);
			end_of_test();
		end
	endtask : limit

	// Ready is offered with the request and held until the answer is sampled
	task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
				break;
		end
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
		// Idle edge so a following call never reassigns ready in the same step
		@(posedge aclk);
		limit(n);
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
				break;
		end
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge aclk);
		limit(n);
	endtask : rd

	task automatic pins_check(input logic [10:0] v);
		logic [31:0] ed;
		logic [31:0] eo;
		int k;
		for (int i = 0; i < 32; i++)
		begin
			k = src(rops_pkg::PIN_GROUP[i], fld[i]);
			ed[i] = (k >= 0);
			eo[i] = (k >= 0) ? v[k] : 1'b0;
		end
		@(negedge aclk);
		chk(pin_drive, ed, "pin drive");
		chk(pin_out, eo, "pin level");
		@(posedge aclk);
	endtask : pins_check

	initial
	begin
		int p;
		int c;
		logic [31:0] d;
		logic [1:0] r;
		logic [10:0] frz;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (p = 0; p < 32; p++)
		begin
			fld[p] = 4'h0;
			rd(rops_pkg::PIN_OFFSET[p], d, r);
			chk(d, 32'h0, "reset value");
			chk(32'(r), 32'h0, "read response");
		end
		pins_check(lvl);
		$display("test reset values done");
		for (p = 0; p < 32; p++)
			for (c = 0; c < 16; c++)
			begin
				rnd = lfsr(rnd);
				lvl <= rnd[10:0];
				wr(rops_pkg::PIN_OFFSET[p], {rnd[31:4], c[3:0]}, r);
				fld[p] = c[3:0];
				chk(32'(r), 32'h0, "write response");
				rd(rops_pkg::PIN_OFFSET[p], d, r);
				chk(d, {28'h0, fld[p]}, "field readback");
				pins_check(lvl);
			end
		$display("test code tables done");
		foreach (bad[i])
		begin
			wr(bad[i], 32'h0000_0007, r);
			chk(32'(r), 32'h2, "unmapped write");
			rd(bad[i], d, r);
			chk(32'(r), 32'h2, "unmapped read");
			chk(d, 32'h0, "unmapped data");
		end
		pins_check(lvl);
		$display("test unmapped offsets done");
		wr(rops_pkg::PIN_OFFSET[0], 32'h0000_0001, r);
		fld[0] = 4'h1;
		chk(32'(r), 32'h0, "write response");
		s_axi_wstrb <= 4'hE;
		rd(rops_pkg::PIN_OFFSET[0], d, r);
		chk(d, 32'h1, "field before strobe test");
		wr(rops_pkg::PIN_OFFSET[0], 32'h0000_0007, r);
		s_axi_wstrb <= 4'hF;
		chk(32'(r), 32'h0, "lane zero off response");
		rd(rops_pkg::PIN_OFFSET[0], d, r);
		chk(d, 32'h1, "lane zero off kept field");
		pins_check(lvl);
		$display("test byte strobe done");
		frz = lvl;
		ce <= 1'b0;
		lvl <= ~frz;
		repeat (3) @(posedge aclk);
		pins_check(frz);
		ce <= 1'b1;
		repeat (2) @(posedge aclk);
		pins_check(lvl);
		$display("test clock enable done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (fld[i])
			fld[i] = 4'h0;
		rd(rops_pkg::PIN_OFFSET[0], d, r);
		chk(d, 32'h0, "field after reset");
		pins_check(lvl);
		$display("test second reset done");
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
